//--- hw/dmx_slot_receiver.sv
// Chosen here: the placing of the registers and the plain strobed port.
`default_nettype none
module slot_fifo
  import dmx_rx_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
)
(
  input wire logic ref_clk, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic in_valid, // Entry offered
  output logic in_ready, // Room for an entry
  input wire logic [WIDTH-1:0] in_data, // Entry in
  output logic out_valid, // Entry waiting
  input wire logic out_ready, // Drain takes entry
  output logic [WIDTH-1:0] out_data // Oldest entry
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH]; // Storage flops
  logic [AW:0] wr_q; // Write pointer, wrap bit on top
  logic [AW:0] rd_q; // Read pointer

  // Full when pointers differ only in the wrap bit; DEPTH must be a power of two
  assign in_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
  assign out_valid = wr_q != rd_q;
  assign out_data = mem_q[rd_q[AW-1:0]];

  // ----------------------------------------
  // Pointers
  // ----------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      if (in_valid && in_ready)
      begin
        wr_q <= wr_q + 1'b1;
      end
      if (out_valid && out_ready)
      begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end

  // Data storage needs no reset: empty slots are never read
  always_ff @(posedge ref_clk)
  begin
    if (in_valid && in_ready)
    begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end
endmodule

module dmx_slot_receiver
  import dmx_rx_pkg::*;
#(
  parameter int TIMEOUT_CYC = TIMEOUT_CYC_DFLT
)
(
  input wire logic ref_clk, // System clock, 20 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic rx_pin, // Serial line, idle high
  input wire logic [7:0] bus_addr, // Register byte address
  input wire logic [31:0] bus_wdata, // Register write data
  input wire logic bus_wr, // Write strobe
  input wire logic bus_rd, // Read strobe
  output logic [31:0] bus_rdata, // Read data, cycle after strobe
  output logic link_common, // Link common, always low
  output dev_chan_type [NUM_DEV-1:0] dev_chan, // Per-device channel bytes
  output logic [NUM_DEV-1:0][15:0] dev_level, // Per-device intensity
  output logic [NUM_DEV-1:0] dev_update, // Device window completed
  output event_type events, // One-cycle event pulses
  output logic rx_timeout // Line silent too long
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic s1_q, s2_q, s3_q; // Pin synchroniser chain
  logic line_q; // Filtered line level
  logic line_prev_q; // Line level one cycle back
  logic line_rise; // Line went high
  logic [LOW_W-1:0] low_cnt_q; // Low duration, saturating
  logic break_evt; // Valid break seen
  logic [IDLE_W-1:0] idle_cnt_q; // Cycles without line activity
  logic tout_evt; // Timeout reached
  rx_state_type state_q; // Slot deserialiser state
  logic [6:0] bit_cnt_q; // Cycles to next sample point
  logic [2:0] bitn_q; // Data bit index
  logic [7:0] shift_q; // Data bits, LSB first
  logic slot_done; // Good slot finished
  logic ferr_evt; // Framing error, not a break
  logic in_packet_q; // A break opened the current packet
  logic [9:0] slot_cnt_q; // Index of the next slot
  logic sc_ok_q; // Start code was the dimming code
  logic [7:0] sc_q; // Last start code
  logic push_valid; // Slot to store
  logic push_ready; // Buffer has room
  slot_type push_e; // Entry to buffer
  logic pop_valid; // Entry waiting
  logic pop_ready; // Router takes entry
  slot_type pop_e; // Entry being routed
  logic [1:0] ctrl_q; // Enable and drain hold
  logic ferr_q; // Sticky framing error
  logic ovr_q; // Sticky overrun
  logic [31:0] rd_mux; // Read value before the flop
  dev_chan_type [NUM_DEV-1:0] chan_q; // Channel storage
  logic [NUM_DEV-1:0] upd_q; // Window done pulses
  logic enable; // Receive enabled

  // Slot s is channel c of device d
  function automatic logic slot_hit(input logic [9:0] s, input int d, input int c);
    return (c < DEV_CHANS[d]) && (s == DEV_START[d] + 10'(c));
  endfunction

  assign enable = ctrl_q[CTRL_EN];
  assign link_common = 1'b0;

  // ----------------------------------------
  // Line synchroniser
  // ----------------------------------------
  // A level change counts once the second and third stages agree
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      line_q <= 1'b1;
      line_prev_q <= 1'b1;
    end
    else
    begin
      s1_q <= rx_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      line_prev_q <= line_q;
      if (s2_q == s3_q)
      begin
        line_q <= s3_q;
      end
    end
  end

  assign line_rise = line_q && !line_prev_q;

  // ----------------------------------------
  // Break capture timer
  // ----------------------------------------
  // Saturating, so a stuck-low line cannot wrap into a short pulse
  always_ff @(posedge ref_clk)
  begin
    if (rst || line_q)
    begin
      low_cnt_q <= '0;
    end
    else if (low_cnt_q != LOW_W'(BREAK_CYC))
    begin
      low_cnt_q <= low_cnt_q + 1'b1;
    end
  end

  assign break_evt = enable && line_rise && (low_cnt_q == LOW_W'(BREAK_CYC));

  // ----------------------------------------
  // Timeout interval timer
  // ----------------------------------------
  // Any edge restarts it; it parks once expired until activity returns
  always_ff @(posedge ref_clk)
  begin
    if (rst || (line_q != line_prev_q))
    begin
      idle_cnt_q <= '0;
    end
    else if (!tout_evt && !rx_timeout)
    begin
      idle_cnt_q <= idle_cnt_q + 1'b1;
    end
  end

  assign tout_evt = !rx_timeout && (line_q == line_prev_q)
                    && (idle_cnt_q == IDLE_W'(TIMEOUT_CYC - 1));

  always_ff @(posedge ref_clk)
  begin
    if (rst || (line_q != line_prev_q))
    begin
      rx_timeout <= 1'b0;
    end
    else if (tout_evt)
    begin
      rx_timeout <= 1'b1;
    end
  end

  // ----------------------------------------
  // Slot deserialiser
  // ----------------------------------------
  // Samples at bit centres; idle waits for a falling edge of any length
  always_ff @(posedge ref_clk)
  begin
    if (rst || !enable)
    begin
      state_q <= RX_IDLE;
      bit_cnt_q <= '0;
      bitn_q <= '0;
      shift_q <= '0;
    end
    else
    begin
      unique case (state_q)
        RX_IDLE:
        begin
          if (!line_q)
          begin
            state_q <= RX_START;
            bit_cnt_q <= 7'(HALF_CYC - 1);
          end
        end
        RX_START:
        begin
          if (bit_cnt_q != '0)
          begin
            bit_cnt_q <= bit_cnt_q - 1'b1;
          end
          else if (!line_q)
          begin
            state_q <= RX_DATA;
            bit_cnt_q <= 7'(BIT_CYC - 1);
            bitn_q <= '0;
          end
          else
          begin
            // Glitch shorter than half a bit
            state_q <= RX_IDLE;
          end
        end
        RX_DATA:
        begin
          if (bit_cnt_q != '0)
          begin
            bit_cnt_q <= bit_cnt_q - 1'b1;
          end
          else
          begin
            shift_q <= {line_q, shift_q[7:1]};
            bit_cnt_q <= 7'(BIT_CYC - 1);
            bitn_q <= bitn_q + 1'b1;
            if (bitn_q == 3'h7)
            begin
              state_q <= RX_STOP1;
            end
          end
        end
        RX_STOP1:
        begin
          if (bit_cnt_q != '0)
          begin
            bit_cnt_q <= bit_cnt_q - 1'b1;
          end
          else
          begin
            bit_cnt_q <= 7'(BIT_CYC - 1);
            state_q <= line_q ? RX_STOP2 : RX_WAIT_HI;
          end
        end
        RX_STOP2:
        begin
          if (bit_cnt_q != '0)
          begin
            bit_cnt_q <= bit_cnt_q - 1'b1;
          end
          else
          begin
            state_q <= line_q ? RX_IDLE : RX_WAIT_HI;
          end
        end
        RX_WAIT_HI:
        begin
          // Break or bad frame: hold until the line returns to mark
          if (line_q)
          begin
            state_q <= RX_IDLE;
          end
        end
        default:
        begin
          state_q <= RX_IDLE;
        end
      endcase
    end
  end

  assign slot_done = (state_q == RX_STOP2) && (bit_cnt_q == '0) && line_q;
  assign ferr_evt = (state_q == RX_WAIT_HI) && line_q && !break_evt;

  // ----------------------------------------
  // Packet tracking
  // ----------------------------------------
  // Errored slots still advance the count so later addresses stay aligned
  always_ff @(posedge ref_clk)
  begin
    if (rst || !enable || tout_evt)
    begin
      in_packet_q <= 1'b0;
      slot_cnt_q <= '0;
      sc_ok_q <= 1'b0;
      sc_q <= '0;
    end
    else if (break_evt)
    begin
      in_packet_q <= 1'b1;
      slot_cnt_q <= '0;
      sc_ok_q <= 1'b0;
    end
    else if (in_packet_q && (slot_done || ferr_evt) && (slot_cnt_q != SLOT_SAT))
    begin
      slot_cnt_q <= slot_cnt_q + 1'b1;
      if (slot_cnt_q == '0)
      begin
        sc_q <= shift_q;
        sc_ok_q <= slot_done && (shift_q == START_CODE_DIM);
      end
    end
  end

  // Only data slots 1..512 enter the buffer
  assign push_valid = in_packet_q && slot_done && (slot_cnt_q != '0)
                      && (slot_cnt_q <= LAST_SLOT);
  assign push_e = '{sc_ok: sc_ok_q, slot: slot_cnt_q, data: shift_q};

  slot_fifo #(.WIDTH($bits(slot_type)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_e),
    .out_valid(pop_valid),
    .out_ready(pop_ready),
    .out_data(pop_e)
  );

  // Software hold stalls the drain; a serial line cannot wait, so a full
  // buffer drops the slot and raises overrun
  assign pop_ready = !ctrl_q[CTRL_HOLD];

  // ----------------------------------------
  // Device router
  // ----------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      chan_q <= '0;
      upd_q <= '0;
    end
    else
    begin
      upd_q <= '0;
      if (pop_valid && pop_ready && pop_e.sc_ok)
      begin
        for (int d = 0; d < NUM_DEV; d++)
        begin
          for (int c = 0; c < MAX_CHANS; c++)
          begin
            if (slot_hit(pop_e.slot, d, c))
            begin
              chan_q[d].chan[c] <= pop_e.data;
              upd_q[d] <= (c == DEV_CHANS[d] - 1);
            end
          end
        end
      end
    end
  end

  assign dev_chan = chan_q;
  assign dev_update = upd_q;

  // First slot of the window is the high byte
  always_comb
  begin
    for (int d = 0; d < NUM_DEV; d++)
    begin
      dev_level[d] = {chan_q[d].chan[0], chan_q[d].chan[1]};
    end
  end

  assign events = '{brk: break_evt, slot: slot_done, tout: tout_evt,
                    ferr: ferr_evt, ovr: push_valid && !push_ready};

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Sticky flags clear by writing one; a same-cycle event wins
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      ctrl_q <= CTRL_RESET;
      ferr_q <= 1'b0;
      ovr_q <= 1'b0;
    end
    else
    begin
      if (bus_wr && (bus_addr == REG_CTRL))
      begin
        ctrl_q <= bus_wdata[1:0];
      end
      if (events.ferr)
      begin
        ferr_q <= 1'b1;
      end
      else if (bus_wr && (bus_addr == REG_STATUS) && bus_wdata[ST_FERR])
      begin
        ferr_q <= 1'b0;
      end
      if (events.ovr)
      begin
        ovr_q <= 1'b1;
      end
      else if (bus_wr && (bus_addr == REG_STATUS) && bus_wdata[ST_OVR])
      begin
        ovr_q <= 1'b0;
      end
    end
  end

  // Read decode; unmapped offsets read zero
  always_comb
  begin
    rd_mux = '0;
    if (bus_addr == REG_CTRL)
    begin
      rd_mux[1:0] = ctrl_q;
    end
    else if (bus_addr == REG_STATUS)
    begin
      rd_mux[ST_FERR] = ferr_q;
      rd_mux[ST_OVR] = ovr_q;
      rd_mux[ST_TOUT] = rx_timeout;
      rd_mux[ST_INPKT] = in_packet_q;
      rd_mux[ST_CODE +: 8] = sc_q;
    end
    for (int d = 0; d < NUM_DEV; d++)
    begin
      if (bus_addr == REG_LEVEL0 + 8'(4 * d))
      begin
        rd_mux[15:0] = dev_level[d];
      end
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge ref_clk)
  begin
    if (rst || !bus_rd)
    begin
      bus_rdata <= '0;
    end
    else
    begin
      bus_rdata <= rd_mux;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_link_low;
    link_common == 1'b0;
  endproperty
  a_link_low: assert property (p_link_low) else $error("link common not low");

  property p_break_restart;
    break_evt |=> (slot_cnt_q == 10'h000) && in_packet_q;
  endproperty
  a_break_restart: assert property (p_break_restart) else $error("break no restart");

  property p_start_code;
    (in_packet_q && slot_done && slot_cnt_q == 10'h000 && !tout_evt)
      |=> sc_ok_q == ($past(shift_q) == 8'h00);
  endproperty
  a_start_code: assert property (p_start_code) else $error("start code check wrong");

  property p_two_stops;
    slot_done |-> $past(state_q, 80) == RX_STOP1 && $past(line_q, 80);
  endproperty
  a_two_stops: assert property (p_two_stops) else $error("stop bits not checked");

  property p_max_slots;
    push_valid |-> slot_cnt_q >= 10'h001 && slot_cnt_q <= 10'h200;
  endproperty
  a_max_slots: assert property (p_max_slots) else $error("slot past 512 stored");

  property p_gap;
    (state_q == RX_IDLE && line_q && enable) |=> state_q == RX_IDLE && !slot_done;
  endproperty
  a_gap: assert property (p_gap) else $error("idle mark left idle");

  property p_break_low;
    break_evt |-> $past(line_q, 2) == 1'b0 && low_cnt_q == LOW_W'(BREAK_CYC);
  endproperty
  a_break_low: assert property (p_break_low) else $error("break without long low");

  property p_timeout;
    tout_evt |=> rx_timeout && !in_packet_q && !tout_evt;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout not flagged");

  property p_foreign_code;
    (pop_valid && pop_ready && !pop_e.sc_ok) |=> $stable(chan_q) && upd_q == '0;
  endproperty
  a_foreign_code: assert property (p_foreign_code) else $error("foreign code stored");

  property p_route;
    (pop_valid && pop_ready && pop_e.sc_ok && pop_e.slot == 10'h005)
      |=> dev_chan[1].chan[0] == $past(pop_e.data);
  endproperty
  a_route: assert property (p_route) else $error("device 2 slot not captured");

  property p_ferr;
    ferr_evt |-> !slot_done ##1 ferr_q;
  endproperty
  a_ferr: assert property (p_ferr) else $error("framing error not flagged");

  c_break: cover property (in_packet_q && slot_done && slot_cnt_q == 10'h000);
  c_dev3: cover property (upd_q[2]);
  c_ferr: cover property (ferr_evt);
  c_ovr: cover property (events.ovr);
endmodule
`default_nettype wire

//--- hw/dmx_rx_pkg.sv
// Contract
// - Valid break restarts slot counting.
// - First slot after mark is start code.
// - Start code 0x00 marks dimming payload.
// - Slot is start, eight data, two stops.
// - Slots beyond 512 ignored until break.
// - Any inter-slot gap keeps alignment; a gap reaching TIMEOUT_CYC cycles ends the packet instead.
// - Idle before break produces no slots.
// - Each device captures consecutive slots from start.
// - Device count configurable, sample uses three.
// - Sample devices start at slots 1, 5, 9.
// - Sample devices capture two channels each.
// - Two slots combine into one intensity value.
// - Capture timer measures line low for break.
// - Interval timer flags receive timeout.
// - Each device's channels readable separately.
// - Link common output held low.
`default_nettype none
package dmx_rx_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int CLK_MHZ = CLK_HZ / 1_000_000;
  localparam int BAUD = 250_000;
  localparam int BIT_CYC = CLK_HZ / BAUD;
  localparam int HALF_CYC = BIT_CYC / 2;
  localparam int BREAK_MIN_US = 88;
  localparam int BREAK_CYC = BREAK_MIN_US * CLK_MHZ;
  localparam int TIMEOUT_US = 1000;
  localparam int TIMEOUT_CYC_DFLT = TIMEOUT_US * CLK_MHZ;
  localparam int LOW_W = 11;
  localparam int IDLE_W = 16;

  // ----------------------------------------
  // Packet layout
  // ----------------------------------------
  localparam logic [7:0] START_CODE_DIM = 8'h00;
  localparam logic [9:0] LAST_SLOT = 10'h200;
  localparam logic [9:0] SLOT_SAT = 10'h3ff;
  localparam int NUM_DEV = 3;
  localparam int MAX_CHANS = 2;
  localparam logic [9:0] DEV_START [NUM_DEV] = '{10'h001, 10'h005, 10'h009};
  localparam int DEV_CHANS [NUM_DEV] = '{2, 2, 2};
  localparam int FIFO_DEPTH = 16;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_LEVEL0 = 8'h08;
  localparam int CTRL_EN = 0;
  localparam int CTRL_HOLD = 1;
  localparam logic [1:0] CTRL_RESET = 2'h1;
  localparam int ST_FERR = 0;
  localparam int ST_OVR = 1;
  localparam int ST_TOUT = 2;
  localparam int ST_INPKT = 3;
  localparam int ST_CODE = 8;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic sc_ok;
    logic [9:0] slot;
    logic [7:0] data;
  } slot_type;

  typedef struct packed {
    logic [MAX_CHANS-1:0][7:0] chan;
  } dev_chan_type;

  typedef struct packed {
    logic brk;
    logic slot;
    logic tout;
    logic ferr;
    logic ovr;
  } event_type;

  typedef enum logic [2:0] {
    RX_IDLE = 3'h0,
    RX_START = 3'h1,
    RX_DATA = 3'h3,
    RX_STOP1 = 3'h2,
    RX_STOP2 = 3'h6,
    RX_WAIT_HI = 3'h4
  } rx_state_type;

endpackage
`default_nettype wire

//--- verif/dmx_tx_model.sv
`default_nettype none
// ----------------------------------------
// Controller model driving the serial line
// ----------------------------------------
module dmx_tx_model
(
  input wire logic ref_clk, // System clock
  output logic rx_pin // Serial line, idle mark high
);
  timeunit 1ns;
  timeprecision 1ns;

  localparam int BIT = 80; // Cycles per bit at 250 kbaud

  // Line rests at mark until the first frame
  initial rx_pin = 1'b1;

  // Drive one level for a number of cycles, always launched on an edge
  task automatic hold_line(input logic lvl, input int cyc);
    rx_pin <= lvl;
    repeat (cyc) @(posedge ref_clk);
  endtask

  // Break, then mark after break; the low time must beat the capture minimum
  task automatic send_break(input int low, input int mab);
    hold_line(1'b0, low);
    hold_line(1'b1, mab);
  endtask

  // One slot: start, eight data lsb first, two stops, then a free gap
  task automatic send_slot(input logic [7:0] b, input int gap, input logic bad);
    hold_line(1'b0, BIT);
    for (int i = 0; i < 8; i++)
    begin
      hold_line(b[i], BIT);
    end
    // A bad slot pulls the first stop bit low, far short of a break
    hold_line(~bad, BIT);
    hold_line(1'b1, BIT + gap);
  endtask
endmodule
`default_nettype wire

//--- verif/testbench.sv
`default_nettype none
module testbench
  import dmx_rx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  localparam int TOUT = 3000; // Longer than a break, so only true silence trips it
  logic ref_clk = 1'b0; // 20 MHz clock
  logic rst = 1'b1; // Synchronous reset
  wire logic rx_pin; // Line from the controller model
  logic [7:0] bus_addr = 8'h00; // Register address
  logic [31:0] bus_wdata = 32'h0; // Write data
  logic bus_wr = 1'b0; // Write strobe
  logic bus_rd = 1'b0; // Read strobe
  logic [31:0] bus_rdata; // Read data
  logic link_common; // Link common output
  dev_chan_type [NUM_DEV-1:0] dev_chan; // Channel bytes
  logic [NUM_DEV-1:0][15:0] dev_level; // Intensities
  logic [NUM_DEV-1:0] dev_update; // Window done pulses
  event_type events; // Event pulses
  logic rx_timeout; // Silence flag
  int bad_count = 0; // Mismatches
  int cmp_count = 0; // Comparisons
  int brk_n = 0, slot_n = 0, ferr_n = 0, ovr_n = 0, tout_n = 0; // Event tallies
  int upd_n [NUM_DEV] = '{0, 0, 0}; // Update tallies

  always #25 ref_clk = ~ref_clk;

  dmx_tx_model dmx_tx_model_i (.ref_clk(ref_clk), .rx_pin(rx_pin));

  dmx_slot_receiver #(.TIMEOUT_CYC(TOUT)) dmx_slot_receiver_i (
    .ref_clk(ref_clk), .rst(rst), .rx_pin(rx_pin), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .link_common(link_common), .dev_chan(dev_chan), .dev_level(dev_level),
    .dev_update(dev_update), .events(events), .rx_timeout(rx_timeout));

  // Pulses last one cycle, so they are tallied at every edge
  always @(posedge ref_clk)
  begin
    if (events.brk === 1'b1) brk_n++;
    if (events.slot === 1'b1) slot_n++;
    if (events.ferr === 1'b1) ferr_n++;
    if (events.ovr === 1'b1) ovr_n++;
    if (events.tout === 1'b1) tout_n++;
    for (int d = 0; d < NUM_DEV; d++)
    begin
      if (dev_update[d] === 1'b1) upd_n[d]++;
    end
  end

  // ----------------------------------------
  // Compare, bus and verdict tasks
  // ----------------------------------------
  task automatic summarize();
    if (bad_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_n(input int got, input int exp);
    cmp_count++;
    if (got != exp)
    begin
      bad_count++;
      $display("CHECK FAILED %0t count %0d expected %0d", $time, got, exp);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= v;
    @(posedge ref_clk);
    bus_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [7:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge ref_clk);
    bus_rd <= 1'b0;
    #1 v = bus_rdata;
  endtask

  // ----------------------------------------
  // Packet helpers
  // ----------------------------------------
  function automatic logic [7:0] val(input int n, input int seed);
    return 8'(n * 29 + seed);
  endfunction

  // Gaps differ slot by slot to stress alignment
  task automatic send_packet(input logic [7:0] sc, input int n, input int seed, input int bad);
    @(posedge ref_clk);
    dmx_tx_model_i.send_break(2000, 240);
    dmx_tx_model_i.send_slot(sc, 10, 1'b0);
    for (int i = 1; i <= n; i++)
    begin
      dmx_tx_model_i.send_slot(val(i, seed), (i % 4) * 37, i == bad);
    end
    repeat (10) @(posedge ref_clk);
  endtask

  // Distinct start slots per device keep the windows apart
  task automatic chk_dev(input int d, input int seed);
    logic [31:0] r;
    int s;
    s = int'(DEV_START[d]);
    chk32({16'h0, dev_level[d]}, {16'h0, val(s, seed), val(s + 1, seed)});
    chk32({24'h0, dev_chan[d].chan[0]}, {24'h0, val(s, seed)});
    reg_read(8'(REG_LEVEL0 + 4 * d), r);
    chk32(r, {16'h0, val(s, seed), val(s + 1, seed)});
  endtask

  task automatic chk_all(input int seed);
    for (int d = 0; d < NUM_DEV; d++)
    begin
      chk_dev(d, seed);
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [31:0] r;
    chk32({31'h0, link_common}, 32'h0);
    chk32({31'h0, rx_timeout}, 32'h0);
    chk32({16'h0, dev_level[0] | dev_level[1] | dev_level[2]}, 32'h0);
    reg_read(REG_CTRL, r);
    chk32(r, 32'h1);
    @(posedge ref_clk);
    #1 chk32(bus_rdata, 32'h0);
    reg_write(8'h40, 32'hffff_ffff);
    reg_read(8'h40, r);
    chk32(r, 32'h0);
    reg_read(REG_CTRL, r);
    chk32(r, 32'h1);
  endtask

  task automatic t_packet();
    int b, s, u;
    b = brk_n;
    s = slot_n;
    u = upd_n[2];
    send_packet(8'h00, 12, 5, 0);
    chk_n(brk_n - b, 1);
    chk_n(slot_n - s, 13);
    chk_n(upd_n[2] - u, 1);
    chk_all(5);
  endtask

  task automatic t_foreign();
    logic [31:0] r;
    send_packet(8'h55, 12, 77, 0);
    chk_all(5);
    reg_read(REG_STATUS, r);
    chk32({24'h0, r[15:8]}, 32'h55);
  endtask

  // A broken slot outside every window must not shift later windows
  task automatic t_ferr();
    logic [31:0] r;
    int f, s;
    f = ferr_n;
    s = slot_n;
    send_packet(8'h00, 12, 9, 3);
    chk_n(ferr_n - f, 1);
    chk_n(slot_n - s, 12);
    chk_all(9);
    reg_read(REG_STATUS, r);
    chk32({31'h0, r[0]}, 32'h1);
    reg_write(REG_STATUS, 32'h1);
    reg_read(REG_STATUS, r);
    chk32({31'h0, r[0]}, 32'h0);
  endtask

  // A second break in mid-packet must renumber from slot one
  task automatic t_restart();
    @(posedge ref_clk);
    dmx_tx_model_i.send_break(2000, 240);
    dmx_tx_model_i.send_slot(8'h00, 10, 1'b0);
    for (int i = 1; i <= 3; i++)
    begin
      dmx_tx_model_i.send_slot(val(i, 40), 20, 1'b0);
    end
    send_packet(8'h00, 2, 50, 0);
    chk_dev(0, 50);
    chk_dev(1, 9);
  endtask

  task automatic t_timeout();
    int t, u, s;
    t = tout_n;
    u = upd_n[1];
    s = slot_n;
    @(posedge ref_clk);
    dmx_tx_model_i.hold_line(1'b1, TOUT + 200);
    chk32({31'h0, rx_timeout}, 32'h1);
    chk_n(tout_n - t, 1);
    chk_n(slot_n - s, 0);
    for (int i = 0; i < 4; i++)
    begin
      dmx_tx_model_i.send_slot(8'h00, 30, 1'b0);
    end
    chk32({31'h0, rx_timeout}, 32'h0);
    chk_n(upd_n[1] - u, 0);
  endtask

  // A disabled receiver must ignore a whole packet
  task automatic t_disable();
    int b;
    b = brk_n;
    reg_write(REG_CTRL, 32'h0);
    send_packet(8'h00, 2, 99, 0);
    chk_n(brk_n - b, 0);
    chk_dev(0, 60);
    reg_write(REG_CTRL, 32'h1);
  endtask

  // Held drain lets the buffer fill; two slots beyond its depth are lost
  task automatic t_overrun();
    logic [31:0] r;
    int o, u, k;
    o = ovr_n;
    u = upd_n[2];
    reg_write(REG_CTRL, 32'h3);
    send_packet(8'h00, FIFO_DEPTH + 2, 60, 0);
    chk_n(ovr_n - o, 2);
    chk_n(upd_n[2] - u, 0);
    reg_read(REG_STATUS, r);
    chk32({31'h0, r[1]}, 32'h1);
    reg_write(REG_CTRL, 32'h1);
    for (k = 0; k < 300 && upd_n[2] == u; k++) @(posedge ref_clk);
    if (k == 300)
    begin
      bad_count++;
      summarize();
    end
    chk_all(60);
    reg_write(REG_STATUS, 32'h2);
    reg_read(REG_STATUS, r);
    chk32({31'h0, r[1]}, 32'h0);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_packet();
    t_foreign();
    t_ferr();
    t_restart();
    t_timeout();
    t_overrun();
    t_disable();
    summarize();
  end
endmodule
`default_nettype wire
